// *** core/tape_cmd_params.svh ***
`ifndef TAPE_CMD_PARAMS_SVH
`define TAPE_CMD_PARAMS_SVH
// control register: go in bit 0, function in bits 5:1
`define CTL_GO_BIT 0
`define CTL_AVAIL_BIT 11
// function codes with go set, as six-bit fields
`define FN_NOP 6'h01
`define FN_REW_OFF 6'h03
`define FN_REWIND 6'h07
`define FN_DRV_CLR 6'h09
`define FN_PRESET 6'h11
`define FN_ERASE 6'h15
`define FN_WR_MARK 6'h17
`define FN_SPC_FWD 6'h19
`define FN_SPC_REV 6'h1b
`define FN_WCHK_FWD 6'h29
`define FN_WCHK_REV 6'h2f
`define FN_WR_FWD 6'h31
`define FN_RD_FWD 6'h39
`define FN_RD_REV 6'h3f
// tape control register fields
`define TC_SLAVE_LSB 0
`define TC_PAR_BIT 3
`define TC_FMT_LSB 4
`define TC_DEN_LSB 8
`define TC_RESET 16'h0000
// preset: slave 0, odd parity (even bit clear), core-dump format, 800 nrzi
`define TC_SLAVE_0 3'h0
`define TC_FMT_CORE 4'h0
`define TC_DEN_800 3'h3
`endif

// *** core/tape_cmd_pkg.sv ***
package tape_cmd_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MOVE = 3'b010,
    ST_SPACE = 3'b100
  } state_e;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_REW_OFF = 4'h1,
    OP_REWIND = 4'h2,
    OP_ERASE = 4'h3,
    OP_WR_MARK = 4'h4,
    OP_SPC_FWD = 4'h5,
    OP_SPC_REV = 4'h6,
    OP_WR_FWD = 4'h7,
    OP_RD_FWD = 4'h8,
    OP_RD_REV = 4'h9
  } xport_op_e;
  typedef struct packed {
    logic start;
    logic clear;
    logic [2:0] slave;
    xport_op_e op;
  } xport_cmd_s;
  typedef struct packed {
    logic drive_ready_flag;
    logic slave_change_flag;
    logic attention_active_flag;
    logic positioning_flag;
    logic tape_mark_flag;
    logic illegal_function_error;
  } status_s;
endpackage : tape_cmd_pkg

// *** core/tape_command_function_decoder.sv ***
`timescale 1ns/1ps
`include "tape_cmd_params.svh"
module tape_command_function_decoder (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ctl_wr,
  input wire logic [5:0] ctl_wdata,
  input wire logic tc_wr,
  input wire logic [15:0] tc_wdata,
  input wire logic [15:0] frame_count,
  input wire logic att_clr,
  input wire logic xport_ready,
  input wire logic beginning_marker,
  input wire logic end_marker,
  input wire logic tape_mark_seen,
  input wire logic record_done,
  input wire logic op_done,
  output logic [5:0] ctl_rdata,
  output logic drive_avail,
  output logic [15:0] tape_control_reg,
  output tape_cmd_pkg::status_s status,
  output logic attention_signal,
  output tape_cmd_pkg::xport_cmd_s xport_cmd
);

  // legal set of fourteen codes, go included
  function automatic logic legal_code(input logic [5:0] c);
    legal_code = (c == `FN_NOP) || (c == `FN_REW_OFF) || (c == `FN_REWIND) ||
      (c == `FN_DRV_CLR) || (c == `FN_PRESET) || (c == `FN_ERASE) ||
      (c == `FN_WR_MARK) || (c == `FN_SPC_FWD) || (c == `FN_SPC_REV) ||
      (c == `FN_WCHK_FWD) || (c == `FN_WCHK_REV) || (c == `FN_WR_FWD) ||
      (c == `FN_RD_FWD) || (c == `FN_RD_REV);
  endfunction : legal_code

  // codes that keep go set and hold the formatter until the transport answers
  function automatic logic motion_code(input logic [5:0] c);
    motion_code = (c == `FN_SPC_FWD) || (c == `FN_SPC_REV) || (c == `FN_ERASE) ||
      (c == `FN_WR_MARK) || (c == `FN_WR_FWD) || (c == `FN_RD_FWD) || (c == `FN_RD_REV) ||
      (c == `FN_WCHK_FWD) || (c == `FN_WCHK_REV);
  endfunction : motion_code

  tape_cmd_pkg::state_e state_q;
  logic [5:0] ctl_q;
  logic [15:0] tc_q;
  logic [15:0] count_q;
  logic space_rev_q;
  logic rew_q;
  logic ssc_q;
  logic ata_q;
  logic tm_q;
  logic ilf_q;
  logic dry_q;
  logic attention_signal_q;
  logic pip_q;
  tape_cmd_pkg::xport_cmd_s cmd_q;

  logic take;
  logic launch;
  logic clr_cmd;
  logic preset_cmd;
  logic rew_cmd;
  logic bad_cmd;
  logic space_cmd;
  logic move_end;
  logic space_end;
  logic ata_set;
  logic ssc_set;

  // commands are taken only while idle; writes during motion are dropped
  assign take = ctl_wr && (state_q == tape_cmd_pkg::ST_IDLE) &&
    ctl_wdata[`CTL_GO_BIT];
  assign bad_cmd = take && !legal_code(ctl_wdata);
  assign launch = take && legal_code(ctl_wdata);
  assign clr_cmd = launch && (ctl_wdata == `FN_DRV_CLR);
  assign preset_cmd = launch && (ctl_wdata == `FN_PRESET);
  assign rew_cmd = launch && ((ctl_wdata == `FN_REWIND) || preset_cmd);
  assign space_cmd = launch && ((ctl_wdata == `FN_SPC_FWD) || (ctl_wdata == `FN_SPC_REV));

  // end of a single record, erase or tape-mark write
  assign move_end = (state_q == tape_cmd_pkg::ST_MOVE) && op_done;

  // space stops on its count, a tape mark, or the marker ahead of it
  assign space_end = (state_q == tape_cmd_pkg::ST_SPACE) &&
    ((record_done && (count_q == 16'h0001)) || tape_mark_seen ||
     (!space_rev_q && end_marker) || (space_rev_q && beginning_marker));

  // events that raise attention or status change
  always_comb begin
    ata_set = 1'b0;
    ssc_set = 1'b0;
    if (launch && (ctl_wdata == `FN_REW_OFF)) begin
      ata_set = 1'b1;
      ssc_set = 1'b1;
    end
    if (rew_cmd) begin
      ata_set = 1'b1;
    end
    if (rew_q && beginning_marker) begin
      ssc_set = 1'b1;
    end
    if (move_end && ((cmd_q.op == tape_cmd_pkg::OP_ERASE) ||
        (cmd_q.op == tape_cmd_pkg::OP_WR_MARK))) begin
      ata_set = 1'b1;
    end
    if (space_end || bad_cmd) begin
      ata_set = 1'b1;
    end
  end

  // formatter state machine
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= tape_cmd_pkg::ST_IDLE;
    end else begin
      case (state_q)
        tape_cmd_pkg::ST_IDLE: begin
          if (launch) begin
            case (ctl_wdata)
              `FN_SPC_FWD, `FN_SPC_REV: state_q <= tape_cmd_pkg::ST_SPACE;
              `FN_ERASE, `FN_WR_MARK, `FN_WR_FWD, `FN_RD_FWD, `FN_RD_REV,
              `FN_WCHK_FWD, `FN_WCHK_REV: state_q <= tape_cmd_pkg::ST_MOVE;
              default: state_q <= tape_cmd_pkg::ST_IDLE;
            endcase
          end
        end
        tape_cmd_pkg::ST_MOVE: begin
          if (op_done) begin
            state_q <= tape_cmd_pkg::ST_IDLE;
          end
        end
        tape_cmd_pkg::ST_SPACE: begin
          if (space_end) begin
            state_q <= tape_cmd_pkg::ST_IDLE;
          end
        end
        default: state_q <= tape_cmd_pkg::ST_IDLE;
      endcase
    end
  end

  // control field; go stays up only while a command is running
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctl_q <= 6'h00;
    end else if (take) begin
      if (launch && motion_code(ctl_wdata)) begin
        ctl_q <= ctl_wdata;
      end else begin
        ctl_q <= {ctl_wdata[5:1], 1'b0};
      end
    end else if (ctl_wr && (state_q == tape_cmd_pkg::ST_IDLE)) begin
      ctl_q <= ctl_wdata; // go clear: stored, no error
    end else if (move_end || space_end) begin
      ctl_q[`CTL_GO_BIT] <= 1'b0;
    end
  end

  // tape control register; preset and drive clear override software
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tc_q <= `TC_RESET;
    end else if (clr_cmd) begin
      tc_q <= `TC_RESET;
    end else if (preset_cmd) begin
      tc_q <= 16'h0000;
      tc_q[`TC_SLAVE_LSB +: 3] <= `TC_SLAVE_0;
      tc_q[`TC_FMT_LSB +: 4] <= `TC_FMT_CORE;
      tc_q[`TC_DEN_LSB +: 3] <= `TC_DEN_800;
    end else if (tc_wr && (state_q == tape_cmd_pkg::ST_IDLE)) begin
      tc_q <= tc_wdata;
    end
  end

  // space record counter; a count of zero runs the full 65536 records
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count_q <= 16'h0000;
      space_rev_q <= 1'b0;
    end else if (launch && ((ctl_wdata == `FN_SPC_FWD) ||
        (ctl_wdata == `FN_SPC_REV))) begin
      count_q <= frame_count;
      space_rev_q <= (ctl_wdata == `FN_SPC_REV);
    end else if ((state_q == tape_cmd_pkg::ST_SPACE) && record_done) begin
      count_q <= count_q - 16'h0001;
    end
  end

  // rewind tracking runs beside the state machine, so the formatter is free
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rew_q <= 1'b0;
    end else if (clr_cmd) begin
      rew_q <= 1'b0;
    end else if (rew_cmd) begin
      rew_q <= 1'b1;
    end else if (beginning_marker) begin
      rew_q <= 1'b0;
    end
  end

  // sticky attention and status change; a new event beats att_clr, drive clear beats both
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ata_q <= 1'b0;
      ssc_q <= 1'b0;
    end else if (clr_cmd) begin
      ata_q <= 1'b0;
      ssc_q <= 1'b0;
    end else begin
      ata_q <= ata_set | (ata_q & ~att_clr);
      ssc_q <= ssc_set | (ssc_q & ~att_clr);
    end
  end

  // tape mark flag holds until drive clear or the next launch of any code other than no-op
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tm_q <= 1'b0;
    end else if (tape_mark_seen && (state_q != tape_cmd_pkg::ST_IDLE)) begin
      tm_q <= 1'b1;
    end else if (clr_cmd || (launch && (ctl_wdata != `FN_NOP))) begin
      tm_q <= 1'b0;
    end
  end

  // illegal function error, cleared only by drive clear
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ilf_q <= 1'b0;
    end else if (bad_cmd) begin
      ilf_q <= 1'b1;
    end else if (clr_cmd) begin
      ilf_q <= 1'b0;
    end
  end

  // ready: formatter idle, and transport able or transport busy rewinding
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dry_q <= 1'b0;
    end else begin
      // only a launch that occupies the formatter drops ready; rewinds keep it up
      dry_q <= (state_q == tape_cmd_pkg::ST_IDLE) && !(launch && motion_code(ctl_wdata)) &&
        (xport_ready || rew_q || rew_cmd || (launch && (ctl_wdata == `FN_REW_OFF)));
    end
  end

  // positioning flag kept in a flop: transport rewinding or formatter spacing
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pip_q <= 1'b0;
    end else if (clr_cmd) begin
      pip_q <= 1'b0;
    end else begin
      pip_q <= rew_cmd || (rew_q && !beginning_marker) || space_cmd ||
        ((state_q == tape_cmd_pkg::ST_SPACE) && !space_end);
    end
  end

  // attention line and its status flag share one source
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      attention_signal_q <= 1'b0;
    end else if (clr_cmd) begin
      attention_signal_q <= 1'b0;
    end else begin
      attention_signal_q <= ata_set | (ata_q & ~att_clr);
    end
  end

  // transport command strobe; drive clear reaches the selected slave only
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cmd_q <= '{start: 1'b0, clear: 1'b0, slave: 3'h0, op: tape_cmd_pkg::OP_NONE};
    end else begin
      cmd_q.start <= launch && (ctl_wdata != `FN_NOP) && (ctl_wdata != `FN_DRV_CLR);
      cmd_q.clear <= clr_cmd;
      if (launch) begin
        cmd_q.slave <= preset_cmd ? `TC_SLAVE_0 : tc_q[`TC_SLAVE_LSB +: 3];
        case (ctl_wdata)
          `FN_REW_OFF: cmd_q.op <= tape_cmd_pkg::OP_REW_OFF;
          `FN_REWIND, `FN_PRESET: cmd_q.op <= tape_cmd_pkg::OP_REWIND;
          `FN_ERASE: cmd_q.op <= tape_cmd_pkg::OP_ERASE;
          `FN_WR_MARK: cmd_q.op <= tape_cmd_pkg::OP_WR_MARK;
          `FN_SPC_FWD: cmd_q.op <= tape_cmd_pkg::OP_SPC_FWD;
          `FN_SPC_REV: cmd_q.op <= tape_cmd_pkg::OP_SPC_REV;
          `FN_WR_FWD: cmd_q.op <= tape_cmd_pkg::OP_WR_FWD;
          `FN_RD_FWD, `FN_WCHK_FWD: cmd_q.op <= tape_cmd_pkg::OP_RD_FWD;
          `FN_RD_REV, `FN_WCHK_REV: cmd_q.op <= tape_cmd_pkg::OP_RD_REV;
          default: cmd_q.op <= tape_cmd_pkg::OP_NONE;
        endcase
      end
    end
  end

  // outputs straight from flops, except drive_avail (bit 11), which is tied high in the formatter
  assign ctl_rdata = ctl_q;
  assign drive_avail = 1'b1;
  assign tape_control_reg = tc_q;
  assign status.drive_ready_flag = dry_q;
  assign status.slave_change_flag = ssc_q;
  assign status.attention_active_flag = ata_q;
  assign status.positioning_flag = pip_q;
  assign status.tape_mark_flag = tm_q;
  assign status.illegal_function_error = ilf_q;
  assign attention_signal = attention_signal_q;
  assign xport_cmd = cmd_q;

endmodule : tape_command_function_decoder

// *** sim/tape_cmd_chk.sv ***
`timescale 1ns/1ps
`include "tape_cmd_params.svh"
module tape_cmd_chk (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ctl_wr,
  input wire logic [5:0] ctl_wdata,
  input wire logic beginning_marker,
  input wire logic tape_mark_seen,
  input wire logic op_done,
  input wire logic [5:0] ctl_rdata,
  input wire logic [15:0] tape_control_reg,
  input wire tape_cmd_pkg::status_s status,
  input wire logic attention_signal,
  input wire tape_cmd_pkg::xport_cmd_s xport_cmd
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic go;
  logic idle;
  // a command counts here only while go and positioning are clear; the formatter also takes one during a rewind
  assign go = ctl_rdata[0];
  assign idle = !go && !status.positioning_flag;
  sequence s_take(logic [5:0] c);
    ctl_wr && idle && ctl_wdata == c;
  endsequence
  sequence s_end;
    go && op_done && !status.positioning_flag;
  endsequence
  a_illegal_code: assert property (
    ctl_wr && idle && ctl_wdata[0] && !(ctl_wdata inside {`FN_NOP, `FN_REW_OFF, `FN_REWIND,
    `FN_DRV_CLR, `FN_PRESET, `FN_ERASE, `FN_WR_MARK, `FN_SPC_FWD, `FN_SPC_REV, `FN_WCHK_FWD,
    `FN_WCHK_REV, `FN_WR_FWD, `FN_RD_FWD, `FN_RD_REV})
    |=> status.illegal_function_error && attention_signal && !go)
    else $error("illegal code not flagged");
  a_rew_offline: assert property (s_take(`FN_REW_OFF) |=> xport_cmd.start && !go &&
    xport_cmd.op == tape_cmd_pkg::OP_REW_OFF && status.drive_ready_flag &&
    status.slave_change_flag && status.attention_active_flag)
    else $error("rewind off-line launch wrong");
  a_rewind_go: assert property (s_take(`FN_REWIND) |=> xport_cmd.start && !go &&
    xport_cmd.op == tape_cmd_pkg::OP_REWIND && status.drive_ready_flag &&
    status.positioning_flag && status.attention_active_flag)
    else $error("rewind launch wrong");
  a_marker_done: assert property (!go && status.positioning_flag && beginning_marker &&
    xport_cmd.op == tape_cmd_pkg::OP_REWIND |=> status.slave_change_flag &&
    !status.positioning_flag)
    else $error("marker did not end rewind");
  a_drive_clr: assert property (s_take(`FN_DRV_CLR) |=> xport_cmd.clear && !go &&
    tape_control_reg == `TC_RESET && !status.illegal_function_error)
    else $error("drive clear wrong");
  a_preset_load: assert property (s_take(`FN_PRESET) |=> xport_cmd.start &&
    tape_control_reg[10:0] == {`TC_DEN_800, `TC_FMT_CORE, 1'b0, `TC_SLAVE_0} &&
    xport_cmd.slave == 3'h0 && xport_cmd.op == tape_cmd_pkg::OP_REWIND)
    else $error("preset wrong");
  a_move_end: assert property (s_end |=> !go && (status.attention_active_flag ||
    !(xport_cmd.op inside {tape_cmd_pkg::OP_ERASE, tape_cmd_pkg::OP_WR_MARK})))
    else $error("move end wrong");
  a_space_abort: assert property (go && status.positioning_flag && tape_mark_seen
    |=> !go && status.attention_active_flag && status.tape_mark_flag)
    else $error("space did not abort");
  a_attention_signal_mirror: assert property (attention_signal == status.attention_active_flag)
    else $error("attention flag and signal differ");
endmodule : tape_cmd_chk

// *** sim/tape_xport_model.sv ***
`timescale 1ns/1ps
module tape_xport_model (
  input wire logic core_clk,
  input wire tape_cmd_pkg::xport_cmd_s xport_cmd,
  input wire logic [15:0] frame_count,
  input wire logic [3:0] dly,
  input wire logic tm_abort,
  output logic beginning_marker,
  output logic end_marker,
  output logic tape_mark_seen,
  output logic record_done,
  output logic op_done
);
  int n;
  logic sp;
  initial {beginning_marker, end_marker, tape_mark_seen, record_done, op_done} = 5'h00;
  // one command at a time; each event is a one-cycle pulse after dly cycles
  always @(posedge core_clk) begin
    if (xport_cmd.start === 1'b1 && xport_cmd.op != tape_cmd_pkg::OP_REW_OFF) begin
      sp = xport_cmd.op inside {tape_cmd_pkg::OP_SPC_FWD, tape_cmd_pkg::OP_SPC_REV};
      n = sp ? int'(frame_count) : 1;
      for (int i = 0; i < n; i++) begin
        repeat (dly) @(posedge core_clk);
        if (xport_cmd.op == tape_cmd_pkg::OP_REWIND) beginning_marker <= 1'b1;
        // a forward space runs into the end marker instead of a mark
        else if (sp && tm_abort && xport_cmd.op == tape_cmd_pkg::OP_SPC_FWD) end_marker <= 1'b1;
        else if (sp && tm_abort) tape_mark_seen <= 1'b1; // mark ahead of the count
        else if (sp) record_done <= 1'b1;
        else op_done <= 1'b1;
        @(posedge core_clk);
        {beginning_marker, end_marker, tape_mark_seen, record_done, op_done} <= 5'h00;
        if (sp && tm_abort) i = n;
      end
    end
  end
endmodule : tape_xport_model

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`include "tape_cmd_params.svh"
module testbench;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic ctl_wr = 1'b0;
  logic tc_wr = 1'b0;
  logic att_clr = 1'b0;
  logic xport_ready = 1'b1;
  logic end_marker;
  logic tm_abort = 1'b0;
  logic [5:0] ctl_wdata = 6'h00;
  logic [15:0] tc_wdata = 16'h0000;
  logic [15:0] frame_count = 16'h0002;
  logic [3:0] dly = 4'h2;
  logic beginning_marker, tape_mark_seen, record_done, op_done, drive_avail, attention_signal;
  logic [5:0] ctl_rdata;
  logic [15:0] tape_control_reg;
  tape_cmd_pkg::status_s status;
  tape_cmd_pkg::xport_cmd_s xport_cmd;
  logic [3:0] exp_q[$];
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int rec_n = 0;
  logic [5:0] bad[6] = '{6'h05, 6'h0b, 6'h0d, 6'h0f, 6'h13, 6'h1d};
  logic [5:0] code[11] = '{`FN_REW_OFF, `FN_ERASE, `FN_WR_MARK, `FN_WCHK_FWD, `FN_WCHK_REV,
    `FN_WR_FWD, `FN_RD_FWD, `FN_RD_REV, `FN_REWIND, `FN_SPC_FWD, `FN_SPC_REV};
  // transport op expected per code, as the package encodes it
  logic [3:0] opv[11] = '{4'h1, 4'h3, 4'h4, 4'h8, 4'h9, 4'h7, 4'h8, 4'h9, 4'h2, 4'h5, 4'h6};
  always #25 core_clk = ~core_clk;
  tape_command_function_decoder dut (.core_clk, .reset, .ctl_wr, .ctl_wdata, .tc_wr, .tc_wdata,
    .frame_count, .att_clr, .xport_ready, .beginning_marker, .end_marker,
    .tape_mark_seen, .record_done, .op_done, .ctl_rdata, .drive_avail, .tape_control_reg,
    .status, .attention_signal, .xport_cmd);
  tape_xport_model xport (.core_clk, .xport_cmd, .frame_count, .dly, .tm_abort,
    .beginning_marker, .end_marker, .tape_mark_seen, .record_done, .op_done);
  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  // one control write; returns just after the edge that takes it
  task automatic cmd(input logic [5:0] c);
    @(posedge core_clk);
    ctl_wr <= 1'b1;
    ctl_wdata <= c;
    @(posedge core_clk);
    ctl_wr <= 1'b0;
    #1;
  endtask : cmd
  task automatic wait_idle;
    int k;
    k = 0;
    while ((ctl_rdata[0] !== 1'b0 || status.positioning_flag !== 1'b0) && k < 400) begin
      @(posedge core_clk);
      k++;
    end
    #1;
    check(k < 400, "command never ended");
  endtask : wait_idle
  // every launch must match the oldest note
  always @(posedge core_clk) begin
    if (!reset && xport_cmd.start === 1'b1) begin
      if (exp_q.size() == 0) check(1'b0, "unexpected launch");
      else check(xport_cmd.op === exp_q.pop_front(), "wrong transport op");
    end
  end
  // records passed while the space still holds go; a hang ends the run
  always @(posedge core_clk) begin
    if (record_done && ctl_rdata[0]) rec_n++;
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      $display("mismatch at %0t: timeout", $time);
      give_verdict();
    end
  end
  initial begin
    void'($urandom(39744));
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    #1;
    check(ctl_rdata === 6'h00 && drive_avail === 1'b1 && status === 6'h20, "reset");
    for (int f = 0; f < 32; f++) begin
      cmd({f[4:0], 1'b0});
      check(ctl_rdata === {f[4:0], 1'b0} && !status.illegal_function_error, "go clear");
    end
    foreach (bad[i]) begin
      cmd(bad[i]);
      check(status.illegal_function_error && attention_signal && !ctl_rdata[0], "illegal");
      cmd(`FN_DRV_CLR);
      check(xport_cmd.clear && !status.illegal_function_error, "drive clear");
    end
    cmd(`FN_NOP);
    check(ctl_rdata[0] === 1'b0, "no-op");
    $display("done: writes, illegal codes, no-op");
    @(posedge core_clk);
    tc_wr <= 1'b1;
    tc_wdata <= 16'($urandom) & 16'h07ff;
    @(posedge core_clk);
    tc_wr <= 1'b0;
    #1;
    check(tape_control_reg === tc_wdata, "tape control write");
    @(posedge core_clk);
    xport_ready <= 1'b0;
    @(posedge core_clk);
    #1;
    check(!status.drive_ready_flag, "ready without transport");
    @(posedge core_clk);
    xport_ready <= 1'b1;
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 11; i++) begin
        dly <= 4'($urandom_range(1, 8));
        frame_count <= 16'($urandom_range(2, 4));
        tm_abort <= r[0];
        rec_n = 0;
        exp_q.push_back(opv[i]);
        cmd(code[i]);
        check(ctl_rdata[0] === !(i == 0 || i == 8), "go after launch");
        check(xport_cmd.slave === tc_wdata[2:0], "slave");
        wait_idle();
        if (i < 3 || i > 7) check(status.attention_active_flag, "attention");
        if (i == 8) check(status.slave_change_flag && !status.positioning_flag, "bot");
        if (i > 8) check(status.tape_mark_flag === (r == 1 && i == 10) &&
          rec_n == (r ? 0 : frame_count), "space count");
        @(posedge core_clk);
        att_clr <= 1'b1;
        @(posedge core_clk);
        att_clr <= 1'b0;
        #1;
        check(!status.attention_active_flag && !attention_signal, "attention clear");
      end
    end
    $display("done: transport commands");
    exp_q.push_back(4'h2);
    cmd(`FN_PRESET);
    check(tape_control_reg[10:0] === 11'h300 && xport_cmd.slave === 3'h0, "preset");
    wait_idle();
    $display("done: preset");
    give_verdict();
  end
endmodule : testbench
bind tape_command_function_decoder tape_cmd_chk chk (.core_clk, .reset, .ctl_wr, .ctl_wdata,
  .beginning_marker, .tape_mark_seen, .op_done, .ctl_rdata, .tape_control_reg, .status,
  .attention_signal, .xport_cmd);
